/* File: hdl/rgb_params.svh */
// Constants of the RGMII DDR/SDR bridge
`ifndef RGB_PARAMS_SVH
`define RGB_PARAMS_SVH

// ****************************************
// Clock and transmit clock half periods
// ****************************************
`define RGB_CLK_NS        25
`define RGB_HALF_1000_NS  4
`define RGB_HALF_100_NS   20
`define RGB_HALF_10_NS    200
`define RGB_CYC(ns)       (((ns) / `RGB_CLK_NS) < 1 ? 1 : ((ns) / `RGB_CLK_NS))
`define RGB_HALF_1000_CYC `RGB_CYC(`RGB_HALF_1000_NS)
`define RGB_HALF_100_CYC  `RGB_CYC(`RGB_HALF_100_NS)
`define RGB_HALF_10_CYC   `RGB_CYC(`RGB_HALF_10_NS)

// ****************************************
// Pin positions in the dedicated pin group
// ****************************************
`define RGB_PIN_TXD_LO    0
`define RGB_PIN_TXCLK     4
`define RGB_PIN_TXCTL     5
`define RGB_PIN_RXCLK     6
`define RGB_PIN_RXCTL     7
`define RGB_PIN_RXD_LO    8
`define RGB_NPINS         12
`define RGB_TX_PIN_MASK   12'h03f
`define RGB_RX_PIN_MASK   12'hfc0

// ****************************************
// Reset speed and transmit clock delay line depth
// ****************************************
`define RGB_RST_SPEED     2'h0
`define RGB_DLY_DEPTH     3

`endif

/* File: hdl/rgb_pkg.sv */
// Types of the RGMII DDR/SDR bridge
package rgb_pkg;

  typedef enum logic [1:0] {
    RGB_SPD_1000 = 2'b00,
    RGB_SPD_100  = 2'b01,
    RGB_SPD_10   = 2'b10
  } rgb_speed_e;

  typedef struct packed {
    logic [7:0] data;
    logic       valid;
    logic       err;
  } rgb_word_s;

endpackage

/* File: hdl/rgb_sync.sv */
// Three-stage input synchroniser with agreement filter
module rgb_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Asynchronous input and filtered level
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change counts once the second and third stages agree
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk) begin
      if (rst) begin
        q[i] <= 1'b0;
      end else if (s2_q[i] == s3_q[i]) begin
        q[i] <= s3_q[i];
      end
    end
  end

endmodule

/* File: hdl/rgb_bridge.sv */
// RGMII double-rate pin bridge to single-rate tile port words
//
// What this block does
// RULE1 - When bridge enabled, dedicated pins leave GPIO use and bridge drives them.
// RULE2 - Convert 4-bit DDR data plus one control wire to 8-bit SDR plus two controls.
// RULE3 - Receive clock with four data bits and control; matching transmit clock likewise.
// RULE4 - Bridge generates transmit clock with selectable delay putting edge out of phase.
// RULE5 - While enabled, dedicated pins serve only the bridge; other pins stay normal.
// RULE6 - Speed switch among 10/100/1000 taken only while valid is low.
// RULE7 - PHY keeps receive clock low while our side is in reset.
// RULE8 - Control carries valid on rising edge, valid xor error on falling edge.
`include "rgb_params.svh"

module rgb_bridge
  import rgb_pkg::*;
#(
  parameter int HALF_1000 = `RGB_HALF_1000_CYC,
  parameter int HALF_100  = `RGB_HALF_100_CYC,
  parameter int HALF_10   = `RGB_HALF_10_CYC,
  parameter int CNT_W     = 8
) (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Configuration
  input  wire logic                   bridge_en,
  input  wire logic [1:0]             speed_sel,
  input  wire logic [1:0]             tx_clk_dly,
  // Dedicated pins
  input  wire logic [`RGB_NPINS-1:0]  pin_in,
  output logic      [`RGB_NPINS-1:0]  pin_out,
  output logic      [`RGB_NPINS-1:0]  pin_oe_n,
  // General purpose use of the same pins
  input  wire logic [`RGB_NPINS-1:0]  gpio_out,
  input  wire logic [`RGB_NPINS-1:0]  gpio_oe_n,
  output logic      [`RGB_NPINS-1:0]  gpio_in,
  // Tile port side, receive
  output rgb_word_s                   rx_word,
  output logic                        rx_stb,
  // Tile port side, transmit
  input  wire rgb_word_s              tx_word,
  output logic                        tx_take,
  output logic      [1:0]             speed_cur
);

  // ****************************************
  // Pin input synchronisation
  // ****************************************
  logic [`RGB_NPINS-1:0] pin_s;

  rgb_sync #(.W(`RGB_NPINS)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (pin_in),
    .q   (pin_s)
  );

  // ****************************************
  // Receive path
  // ****************************************
  logic       rxclk_prev_q;
  logic [3:0] rx_lo_q;
  logic       rx_vld_q;
  logic       rx_stb_q;
  rgb_word_s  rx_word_q;

  wire       rxclk_lvl = pin_s[`RGB_PIN_RXCLK];
  wire       rx_ctl    = pin_s[`RGB_PIN_RXCTL];
  wire [3:0] rx_nib    = pin_s[`RGB_PIN_RXD_LO +: 4];
  // Clock held low by the PHY during our reset gives no stray edge [RULE7]
  wire       rx_rise   = bridge_en & rxclk_lvl & ~rxclk_prev_q; // [RULE3]
  wire       rx_fall   = bridge_en & ~rxclk_lvl & rxclk_prev_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rxclk_prev_q <= 1'b0;
      rx_lo_q      <= 4'h0;
      rx_vld_q     <= 1'b0;
      rx_stb_q     <= 1'b0;
      rx_word_q    <= '0;
    end else begin
      rxclk_prev_q <= rxclk_lvl;
      rx_stb_q     <= rx_fall;
      if (rx_rise) begin
        rx_lo_q  <= rx_nib; // [RULE2]
        rx_vld_q <= rx_ctl; // [RULE8]
      end
      // A fall with no rise before it pairs with a stale low nibble
      if (rx_fall) begin
        rx_word_q.data  <= {rx_nib, rx_lo_q}; // [RULE2]
        rx_word_q.valid <= rx_vld_q; // [RULE8]
        rx_word_q.err   <= rx_vld_q ^ rx_ctl; // [RULE8]
      end
    end
  end

  // ****************************************
  // Transmit clock divider
  // ****************************************
  logic [CNT_W-1:0]          cnt_q;
  logic                      phase_q;
  logic [1:0]                speed_q;
  logic                      tx_vld_q;
  logic [`RGB_DLY_DEPTH-1:0] dly_q;

  // Unused select code falls back to the gigabit half period
  wire [CNT_W-1:0] half_sel =
    (speed_q == RGB_SPD_10)  ? CNT_W'(HALF_10) :
    (speed_q == RGB_SPD_100) ? CNT_W'(HALF_100) : CNT_W'(HALF_1000);
  // Greater-or-equal keeps the divider safe when a shorter half period is loaded
  wire tick     = bridge_en & (cnt_q >= half_sel - CNT_W'(1));
  wire tx_rise  = tick & ~phase_q;
  wire tx_fall  = tick & phase_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q   <= '0;
      phase_q <= 1'b0;
    end else begin
      cnt_q   <= tick ? '0 : (bridge_en ? cnt_q + CNT_W'(1) : '0);
      phase_q <= tick ? ~phase_q : (phase_q & bridge_en); // [RULE4]
    end
  end

  // ****************************************
  // Speed switch
  // ****************************************
  // Speed is taken only at a transmit clock fall while valid is low [RULE6]
  wire spd_load = tx_fall & ~tx_vld_q & ~tx_word.valid;

  always_ff @(posedge clk) begin
    if (rst) begin
      speed_q <= `RGB_RST_SPEED;
    end else if (spd_load) begin
      speed_q <= speed_sel; // [RULE6]
    end
  end

  // ****************************************
  // Transmit clock delay line
  // ****************************************
  // Delayed copy of the clock phase for the pin [RULE4]
  // Zero bypasses the line; the pin register adds one more cycle in every case
  wire clk_pin  = (tx_clk_dly == 2'h0) ? phase_q : dly_q[tx_clk_dly - 2'h1];

  always_ff @(posedge clk) begin
    if (rst) begin
      dly_q <= '0;
    end else begin
      dly_q <= {dly_q[`RGB_DLY_DEPTH-2:0], phase_q}; // [RULE4]
    end
  end

  // ****************************************
  // Transmit data path
  // ****************************************
  logic [3:0] tx_hi_q;
  logic       tx_err_q;
  logic [3:0] txd_q;
  logic       txctl_q;
  logic       tx_take_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_hi_q   <= 4'h0;
      tx_err_q  <= 1'b0;
      tx_vld_q  <= 1'b0;
      txd_q     <= 4'h0;
      txctl_q   <= 1'b0;
      tx_take_q <= 1'b0;
    end else begin
      tx_take_q <= tx_rise;
      if (tx_rise) begin
        txd_q    <= tx_word.data[3:0]; // [RULE2]
        tx_hi_q  <= tx_word.data[7:4];
        tx_vld_q <= tx_word.valid;
        tx_err_q <= tx_word.err;
        txctl_q  <= tx_word.valid; // [RULE8]
      end else if (tx_fall) begin
        txd_q   <= tx_hi_q; // [RULE2]
        txctl_q <= tx_vld_q ^ tx_err_q; // [RULE8]
      end
    end
  end

  // ****************************************
  // Pin ownership
  // ****************************************
  logic [`RGB_NPINS-1:0] pin_out_q;
  logic [`RGB_NPINS-1:0] pin_oe_n_q;
  logic [`RGB_NPINS-1:0] gpio_in_q;

  wire [`RGB_NPINS-1:0] br_out  = {6'h00, txctl_q, clk_pin, txd_q};
  // Receive pins stay inputs; transmit pins are driven
  wire [`RGB_NPINS-1:0] br_oe_n = `RGB_RX_PIN_MASK;
  wire [`RGB_NPINS-1:0] mux_out = bridge_en ? br_out : gpio_out; // [RULE1]
  wire [`RGB_NPINS-1:0] mux_oe  = bridge_en ? br_oe_n : gpio_oe_n; // [RULE1]
  // Bridge pins are hidden from general purpose reads [RULE5]
  wire [`RGB_NPINS-1:0] mux_in  = bridge_en ? {`RGB_NPINS{1'b0}} : pin_s;

  always_ff @(posedge clk) begin
    if (rst) begin
      pin_out_q  <= '0;
      pin_oe_n_q <= '1;
      gpio_in_q  <= '0;
    end else begin
      pin_out_q  <= mux_out;
      pin_oe_n_q <= mux_oe;
      gpio_in_q  <= mux_in; // [RULE5]
    end
  end

  assign pin_out   = pin_out_q;
  assign pin_oe_n  = pin_oe_n_q;
  assign gpio_in   = gpio_in_q;
  assign rx_word   = rx_word_q;
  assign rx_stb    = rx_stb_q;
  assign tx_take   = tx_take_q;
  assign speed_cur = speed_q;

endmodule

/* File: dv/rgb_bridge_monitor.sv */
// Checker of the bridge port relations
`include "rgb_params.svh"
module rgb_bridge_monitor
  import rgb_pkg::*;
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  rst,
  // Pins and their general purpose use
  input wire logic                  bridge_en,
  input wire logic [`RGB_NPINS-1:0] pin_out,
  input wire logic [`RGB_NPINS-1:0] pin_oe_n,
  input wire logic [`RGB_NPINS-1:0] gpio_out,
  input wire logic [`RGB_NPINS-1:0] gpio_oe_n,
  input wire logic [`RGB_NPINS-1:0] gpio_in,
  // Tile port side
  input wire rgb_word_s             rx_word,
  input wire logic                  rx_stb,
  input wire rgb_word_s             tx_word,
  input wire logic                  tx_take,
  input wire logic [1:0]            speed_cur
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_own; bridge_en |=> pin_oe_n == `RGB_RX_PIN_MASK; endproperty
  a_own: assert property (p_own) else $error("pins not owned");
  property p_gpio;
    !rst && !bridge_en |=> pin_out == $past(gpio_out) && pin_oe_n == $past(gpio_oe_n);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio drive lost");
  property p_gin; bridge_en |=> gpio_in == '0; endproperty
  a_gin: assert property (p_gin) else $error("gpio input leaks");
  property p_rxq; !bridge_en [*8] |=> !rx_stb; endproperty
  a_rxq: assert property (p_rxq) else $error("receive while off");
  property p_rxp; rx_stb |=> !rx_stb; endproperty
  a_rxp: assert property (p_rxp) else $error("receive strobe long");
  property p_rxh; !rx_stb |-> $stable(rx_word); endproperty
  a_rxh: assert property (p_rxh) else $error("receive word moved");
  property p_txp; tx_take |=> !tx_take; endproperty
  a_txp: assert property (p_txp) else $error("transmit take long");
  property p_spi; !bridge_en |=> $stable(speed_cur); endproperty
  a_spi: assert property (p_spi) else $error("speed moved while off");
  property p_spv; $changed(speed_cur) |-> !$past(tx_word.valid); endproperty
  a_spv: assert property (p_spv) else $error("speed moved while valid");
  c_rx: cover property (rx_stb && rx_word.valid);
  c_tx: cover property (tx_take && tx_word.valid);
  c_sp: cover property ($changed(speed_cur));
endmodule
bind rgb_bridge rgb_bridge_monitor rgb_bridge_monitor_i (.clk(clk), .rst(rst),
  .bridge_en(bridge_en), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .gpio_out(gpio_out),
  .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in), .rx_word(rx_word), .rx_stb(rx_stb),
  .tx_word(tx_word), .tx_take(tx_take), .speed_cur(speed_cur));

/* File: dv/rgb_phy_model.sv */
// Receive side of the external PHY
module rgb_phy_model (
  // Receive pins
  output logic       rx_clk,
  output logic       rx_ctl,
  output logic [3:0] rx_d
);
  timeunit 1ns;
  timeprecision 1ps;
  // Clock stands low through reset and between frames
  initial begin
    rx_clk = 1'b0;
    rx_ctl = 1'b0;
    rx_d = 4'h0;
  end
  // One 200 ns clock: low nibble and valid at rise, high nibble and valid^err at fall
  task automatic send(input logic [7:0] b, input logic v, input logic e);
    rx_d = b[3:0];
    rx_ctl = v;
    #50 rx_clk = 1'b1;
    #50 rx_d = b[7:4];
    rx_ctl = v ^ e;
    #50 rx_clk = 1'b0;
    #50 rx_d = ~rx_d;
    rx_ctl = ~rx_ctl;
  endtask
endmodule

/* File: dv/testbench.sv */
// Bench of the bridge against a PHY model
`include "rgb_params.svh"
module testbench
  import rgb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rst, bridge_en, rx_clk, rx_ctl, rx_stb, tx_take;
  logic [1:0]  speed_sel, tx_clk_dly, speed_cur;
  logic [3:0]  rx_d;
  logic [11:0] pin_out, pin_oe_n, gpio_out, gpio_oe_n, gpio_in;
  rgb_word_s   rx_word, tx_word, got;
  int          failures, comparisons, rx_cnt = 0;
  rgb_phy_model rgb_phy_model_i (.rx_clk(rx_clk), .rx_ctl(rx_ctl), .rx_d(rx_d));
  rgb_bridge rgb_bridge_i (.clk(clk), .rst(rst), .bridge_en(bridge_en), .speed_sel(speed_sel),
    .tx_clk_dly(tx_clk_dly), .pin_in({rx_d, rx_ctl, rx_clk, 6'h15}), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .gpio_in(gpio_in),
    .rx_word(rx_word), .rx_stb(rx_stb), .tx_word(tx_word), .tx_take(tx_take),
    .speed_cur(speed_cur));
  // ****************************************
  // Helpers
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) if (rx_stb === 1'b1) begin
    got <= rx_word;
    rx_cnt <= rx_cnt + 1;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (failures == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_gpio();
    cyc(8);
    check(pin_out, gpio_out);
    check(pin_oe_n, gpio_oe_n);
    check(gpio_in, 12'h015);
    check(12'(rx_cnt), 12'h000);
    @(posedge clk) bridge_en <= 1'b1;
    cyc(2);
    check(pin_oe_n, 12'hfc0);
    check(gpio_in, 12'h000);
  endtask
  task automatic t_rx();
    logic [7:0] b;
    logic v, e;
    for (int i = 0; i < 3; i++) begin
      b = {4'(12 - i), 4'(5 + i)};
      v = (i != 2);
      e = (i != 0);
      rgb_phy_model_i.send(b, v, e);
      cyc(8);
      check(12'(rx_cnt), 12'(i + 1));
      check({2'h0, got}, {2'h0, b, v, e});
    end
  endtask
  task automatic t_tx();
    for (int i = 0; i < 3; i++) begin
      @(posedge clk) tx_word <= '0;
      speed_sel <= 2'(i);
      for (int k = 0; k < 200 && speed_cur !== 2'(i); k++) cyc(1);
      check(12'(speed_cur), 12'(i));
      @(posedge clk) tx_word <= '{data: 8'h96, valid: 1'b1, err: i[0]};
      cyc(2);
      for (int k = 0; k < 40 && tx_take !== 1'b1; k++) cyc(1);
      check({11'h0, tx_take}, 12'h001);
      cyc(1);
      check({7'h0, pin_out[5], pin_out[3:0]}, 12'h016);
      if (i == 2) begin
        check({11'h0, pin_out[4]}, 12'h000);
        cyc(1);
        check({11'h0, pin_out[4]}, 12'h000);
        cyc(1);
        check({11'h0, pin_out[4]}, 12'h001);
      end
      for (int k = 0; k < 20 && pin_out[3:0] !== 4'h9; k++) cyc(1);
      check({7'h0, pin_out[5], pin_out[3:0]}, {7'h0, ~i[0], 4'h9});
    end
    @(posedge clk) speed_sel <= 2'h0;
    cyc(60);
    check(12'(speed_cur), 12'h002);
    @(posedge clk) tx_word <= '0;
  endtask
  initial begin
    failures = 0;
    comparisons = 0;
    rst = 1'b1;
    bridge_en = 1'b0;
    speed_sel = 2'h0;
    tx_clk_dly = 2'h2;
    gpio_out = 12'ha5c;
    gpio_oe_n = 12'h0f3;
    tx_word = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_gpio();
    t_rx();
    t_tx();
    close_out();
  end
  initial begin
    #100us;
    failures++;
    close_out();
  end
endmodule
